// ### urbt_pkg.sv
package urbt_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] A_DATA = 8'h00;
    localparam logic [7:0] A_FIFO_CTRL = 8'h04;
    localparam logic [7:0] A_LCR = 8'h08;
    localparam logic [7:0] A_MODEM_CTRL = 8'h0C;
    localparam logic [7:0] A_LINE_STAT = 8'h10;
    localparam logic [7:0] A_DLL = 8'h14;
    localparam logic [7:0] A_DIV_HI = 8'h18;
    localparam logic [7:0] A_ALT_FUNC = 8'h1C;
    localparam logic [7:0] A_FEATURE = 8'h20;
    localparam logic [7:0] A_TRG = 8'h24;
    localparam logic [7:0] A_FLVL = 8'h28;
    // ------------------------------------------------------------
    // field positions, field values and write mask
    // ------------------------------------------------------------
    localparam int FC_FIFO_EN = 0;
    localparam int FC_RX_CLR = 1;
    localparam int FC_TX_CLR = 2;
    localparam int FC_BLOCK = 3;
    localparam int MC_PRESCALE = 7;
    localparam int AF_MF_LO = 1;
    localparam int FEAT_HDX = 3;
    localparam int LS_RX_DATA = 0;
    localparam int LS_HOLD_EMPTY = 5;
    localparam int LS_TX_EMPTY = 6;
    localparam logic [1:0] MF_RX_READY = 2'h2;
    localparam logic [7:0] FC_KEEP = 8'h09;
    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] FC_RST = 8'h00;
    localparam logic [4:0] LCR_RST = 5'h03;
    localparam logic [7:0] MC_RST = 8'h00;
    localparam logic [7:0] AF_RST = 8'h00;
    localparam logic [7:0] FEAT_RST = 8'h00;
    localparam logic [7:0] DLL_RST = 8'h01;
    localparam logic [7:0] DIV_HI_RST = 8'h00;
    localparam logic [7:0] TX_TRIG_RST = 8'h08;
    localparam logic [7:0] RX_TRIG_RST = 8'h08;
    localparam logic [1:0] PRESCALE_LAST = 2'h3;
    localparam logic [3:0] SAMPLE_LAST = 4'hF;
    localparam logic [2:0] MIN_DATA_BITS = 3'h5;

    typedef struct packed {
        logic par_even;
        logic par_en;
        logic stop2;
        logic [1:0] wlen;
    } urbt_lcr_s;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} urbt_tx_e;
endpackage : urbt_pkg

// ### urbt_top.sv
`timescale 1ns/1ps
module urbt_top
    import urbt_pkg::*;
#(
    parameter int DEPTH = 128
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_timeout,
    output logic tx_out,
    output logic sample_tick16,
    output logic tx_ready_pin_n,
    output logic rx_ready_pin_n,
    output logic multifunction_pin_n,
    output logic irq_out_first_channel
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CAP_FIFO = CW'(DEPTH);
    localparam logic [CW-1:0] CAP_ONE = CW'(1);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] fifo_control_register;
    logic [7:0] modem_control_register;
    logic [7:0] alternate_function_register;
    logic [7:0] feature_control_register;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high_byte;
    logic [7:0] tx_trig;
    logic [7:0] rx_trig;
    urbt_lcr_s line_ctrl;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire acc = psel & penable;
    wire done = acc & pready;
    wire wr = done & pwrite;
    wire rd = done & ~pwrite;
    wire hit_data = paddr == A_DATA;
    wire hit_fc = paddr == A_FIFO_CTRL;
    wire hit_lcr = paddr == A_LCR;
    wire hit_mc = paddr == A_MODEM_CTRL;
    wire hit_ls = paddr == A_LINE_STAT;
    wire hit_dll = paddr == A_DLL;
    wire hit_dh = paddr == A_DIV_HI;
    wire hit_af = paddr == A_ALT_FUNC;
    wire hit_feat = paddr == A_FEATURE;
    wire hit_trg = paddr == A_TRG;
    wire hit_flvl = paddr == A_FLVL;
    wire mapped = hit_data | hit_fc | hit_lcr | hit_mc | hit_ls | hit_dll
                | hit_dh | hit_af | hit_feat | hit_trg | hit_flvl;

    wire fifo_en = fifo_control_register[FC_FIFO_EN];
    wire block_mode = fifo_en & fifo_control_register[FC_BLOCK];
    wire hdx_mode = feature_control_register[FEAT_HDX];
    wire [CW-1:0] cap = fifo_en ? CAP_FIFO : CAP_ONE;
    // toggling fifo enable flushes both fifos so stale bytes never leak across modes
    wire fifo_flip = wr & hit_fc & (pwdata[FC_FIFO_EN] != fifo_en);
    wire tx_clr = fifo_flip | (wr & hit_fc & pwdata[FC_TX_CLR]);
    wire rx_clr = fifo_flip | (wr & hit_fc & pwdata[FC_RX_CLR]);

    // ------------------------------------------------------------
    // fifo storage
    // ------------------------------------------------------------
    logic [7:0] tx_mem [DEPTH];
    logic [7:0] rx_mem [DEPTH];
    logic [PW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
    logic [CW-1:0] tx_cnt, rx_cnt;
    logic tx_pop;

    wire tx_empty = tx_cnt == '0;
    wire rx_empty = rx_cnt == '0;
    // pushes into a full fifo are dropped; depth must be a power of two
    wire tx_push = wr & hit_data & (tx_cnt != cap);
    wire rx_push = rx_valid & (rx_cnt != cap);
    wire rx_pop = rd & hit_data & ~rx_empty;
    wire [7:0] tx_head = tx_mem[tx_rp];
    wire [7:0] rx_head = rx_empty ? 8'h00 : rx_mem[rx_rp];

    always_ff @(posedge pclk) begin
        if (ce && tx_push) begin
            tx_mem[tx_wp] <= pwdata[7:0];
        end
        if (ce && rx_push) begin
            rx_mem[rx_wp] <= rx_byte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_wp <= '0;
            tx_rp <= '0;
            tx_cnt <= '0;
        end else if (ce && tx_clr) begin
            tx_wp <= '0;
            tx_rp <= '0;
            tx_cnt <= '0;
        end else if (ce) begin
            tx_wp <= tx_push ? PW'(tx_wp + 1'b1) : tx_wp;
            tx_rp <= tx_pop ? PW'(tx_rp + 1'b1) : tx_rp;
            tx_cnt <= CW'(tx_cnt + CW'(tx_push) - CW'(tx_pop));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_wp <= '0;
            rx_rp <= '0;
            rx_cnt <= '0;
        end else if (ce && rx_clr) begin
            rx_wp <= '0;
            rx_rp <= '0;
            rx_cnt <= '0;
        end else if (ce) begin
            rx_wp <= rx_push ? PW'(rx_wp + 1'b1) : rx_wp;
            rx_rp <= rx_pop ? PW'(rx_rp + 1'b1) : rx_rp;
            rx_cnt <= CW'(rx_cnt + CW'(rx_push) - CW'(rx_pop));
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_control_register <= FC_RST;
            line_ctrl <= LCR_RST;
            modem_control_register <= MC_RST;
            alternate_function_register <= AF_RST;
            feature_control_register <= FEAT_RST;
            divisor_low <= DLL_RST;
            divisor_high_byte <= DIV_HI_RST;
            tx_trig <= TX_TRIG_RST;
            rx_trig <= RX_TRIG_RST;
        end else if (ce && wr) begin
            if (hit_fc) begin
                fifo_control_register <= pwdata[7:0] & FC_KEEP;
            end
            if (hit_lcr) begin
                line_ctrl <= pwdata[4:0];
            end
            if (hit_mc) begin
                modem_control_register <= pwdata[7:0];
            end
            if (hit_af) begin
                alternate_function_register <= pwdata[7:0];
            end
            if (hit_feat) begin
                feature_control_register <= pwdata[7:0];
            end
            if (hit_dll) begin
                divisor_low <= pwdata[7:0];
            end
            if (hit_dh) begin
                divisor_high_byte <= pwdata[7:0];
            end
            if (hit_trg) begin
                tx_trig <= pwdata[7:0];
                rx_trig <= pwdata[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // prescaler and baud divider
    // ------------------------------------------------------------
    // pclk stands in for the oscillator; the bus needs no baud tick
    logic [1:0] pre_cnt;
    logic [15:0] baud_cnt;
    wire presc4 = modem_control_register[MC_PRESCALE];
    wire pre_tick = ~presc4 | (pre_cnt == PRESCALE_LAST);
    wire [15:0] divisor = {divisor_high_byte, divisor_low};
    wire div_ok = divisor != 16'h0000;
    wire btick = pre_tick & div_ok & (baud_cnt <= 16'h0001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt <= 2'h0;
            baud_cnt <= 16'h0000;
            sample_tick16 <= 1'b0;
        end else if (ce) begin
            pre_cnt <= presc4 ? 2'(pre_cnt + 2'h1) : 2'h0;
            if (pre_tick) begin
                // zero divisor parks the count so a new divisor ticks at once
                baud_cnt <= (btick || !div_ok) ? divisor : 16'(baud_cnt - 16'h0001);
            end
            sample_tick16 <= btick;
        end
    end

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    urbt_tx_e state;
    logic [3:0] sub;
    logic [2:0] bit_idx;
    logic [7:0] shreg;
    logic par_bit;
    logic stop_idx;

    wire [7:0] mask = 8'hFF >> (2'h3 - line_ctrl.wlen);
    wire [2:0] last_bit = 3'(MIN_DATA_BITS + {1'b0, line_ctrl.wlen} - 3'h1);
    wire head_par = line_ctrl.par_even ? ^(tx_head & mask) : ~^(tx_head & mask);
    wire bit_end = btick & (sub == SAMPLE_LAST);
    wire tx_idle = state == TX_IDLE;
    assign tx_pop = btick & tx_idle & ~tx_empty & ~tx_clr;
    wire line_bit = (state == TX_START) ? 1'b0
                  : (state == TX_DATA) ? shreg[0]
                  : (state == TX_PARITY) ? par_bit : 1'b1;

    urbt_tx_e next_state;
    always_comb begin
        next_state = state;
        case (state)
            TX_IDLE: begin
                if (tx_pop) begin
                    next_state = TX_START;
                end
            end
            TX_START: begin
                if (bit_end) begin
                    next_state = TX_DATA;
                end
            end
            TX_DATA: begin
                if (bit_end && bit_idx == last_bit) begin
                    next_state = line_ctrl.par_en ? TX_PARITY : TX_STOP;
                end
            end
            TX_PARITY: begin
                if (bit_end) begin
                    next_state = TX_STOP;
                end
            end
            TX_STOP: begin
                if (bit_end && (stop_idx || !line_ctrl.stop2)) begin
                    next_state = TX_IDLE;
                end
            end
            default: begin
                next_state = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= TX_IDLE;
            sub <= 4'h0;
            bit_idx <= 3'h0;
            shreg <= 8'h00;
            par_bit <= 1'b0;
            stop_idx <= 1'b0;
            tx_out <= 1'b1;
        end else if (ce) begin
            state <= next_state;
            tx_out <= line_bit;
            if (btick) begin
                sub <= tx_idle ? 4'h0 : 4'(sub + 4'h1);
            end
            if (tx_pop) begin
                shreg <= tx_head;
                par_bit <= head_par;
                bit_idx <= 3'h0;
                stop_idx <= 1'b0;
            end else if (bit_end && state == TX_DATA) begin
                shreg <= {1'b0, shreg[7:1]};
                bit_idx <= 3'(bit_idx + 3'h1);
            end else if (bit_end && state == TX_STOP) begin
                stop_idx <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // ready pins and interrupt pin
    // ------------------------------------------------------------
    logic rx_blk_n;
    wire [7:0] tx_lvl = 8'(tx_cnt);
    wire [7:0] rx_lvl = 8'(rx_cnt);
    wire rx_at_trig = rx_lvl >= rx_trig;
    wire tx_all_empty = tx_empty & tx_idle;
    wire next_tx_rdy_n = block_mode ? (tx_cnt == cap) : ~tx_empty;
    // empty releases the pin; empty wins over a trigger or timeout in the same cycle
    wire next_rx_blk_n = (!rx_empty && (rx_at_trig || rx_timeout)) ? 1'b0
                       : rx_empty ? 1'b1 : rx_blk_n;
    wire next_rx_rdy_n = block_mode ? next_rx_blk_n : rx_empty;
    wire tx_irq_hi = !fifo_en ? tx_empty
                   : hdx_mode ? (tx_lvl < tx_trig) | tx_all_empty
                   : (tx_lvl < tx_trig) | tx_empty;
    wire rx_irq_hi = fifo_en ? rx_at_trig : ~rx_empty;
    wire mf_rx = alternate_function_register[AF_MF_LO +: 2] == MF_RX_READY;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_blk_n <= 1'b1;
            tx_ready_pin_n <= 1'b0;
            rx_ready_pin_n <= 1'b1;
            multifunction_pin_n <= 1'b1;
            irq_out_first_channel <= 1'b1;
        end else if (ce) begin
            rx_blk_n <= next_rx_blk_n;
            tx_ready_pin_n <= next_tx_rdy_n;
            rx_ready_pin_n <= next_rx_rdy_n;
            multifunction_pin_n <= mf_rx ? next_rx_rdy_n : 1'b1;
            irq_out_first_channel <= tx_irq_hi | rx_irq_hi;
        end
    end

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    wire [7:0] line_stat = {1'b0, tx_all_empty, tx_empty, 4'h0, ~rx_empty};
    wire [31:0] rdata = hit_data ? {24'h0, rx_head}
                      : hit_fc ? {24'h0, fifo_control_register}
                      : hit_lcr ? {27'h0, line_ctrl}
                      : hit_mc ? {24'h0, modem_control_register}
                      : hit_ls ? {24'h0, line_stat}
                      : hit_dll ? {24'h0, divisor_low}
                      : hit_dh ? {24'h0, divisor_high_byte}
                      : hit_af ? {24'h0, alternate_function_register}
                      : hit_feat ? {24'h0, feature_control_register}
                      : hit_trg ? {16'h0, rx_trig, tx_trig}
                      : hit_flvl ? {16'h0, rx_lvl, tx_lvl} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (ce) begin
            pready <= acc & ~pready;
            pslverr <= acc & ~pready & ~mapped;
            if (acc && !pready) begin
                prdata <= pwrite ? 32'h0 : rdata;
            end
        end
    end
endmodule : urbt_top

// ### urbt_top_sva.sv
`timescale 1ns/1ps
// ----
// port checker
// ----
module urbt_sva
    import urbt_pkg::*;
#(
    parameter int DEPTH = 128
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_valid,
    input wire logic rx_timeout,
    input wire logic tx_out,
    input wire logic sample_tick16,
    input wire logic tx_ready_pin_n,
    input wire logic rx_ready_pin_n,
    input wire logic multifunction_pin_n
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic prev_tx;
    logic [7:0] run;
    wire apb_wr = psel & penable & pready & pwrite;
    wire rx_cause = rx_valid | rx_timeout | apb_wr;
    // ticks per low run; the idle-to-start edge has no fixed length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_tx <= 1'b1;
            run <= 8'h00;
        end else begin
            prev_tx <= tx_out;
            run <= (tx_out != prev_tx) ? {7'h00, sample_tick16} : run + {7'h00, sample_tick16};
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    apb_wait_a: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
        else $error("pready missed second access cycle");
    ready_once_a: assert property (pready |=> !pready)
        else $error("pready held two cycles");
    err_pair_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    bit_len_a: assert property (tx_out && !prev_tx |-> run[3:0] == 4'h0 && run != 8'h00)
        else $error("serial bit not sixteen ticks");
    tx_tick_a: assert property ($changed(tx_out) |-> $past(sample_tick16))
        else $error("serial line moved without tick");
    mf_route_a: assert property (!multifunction_pin_n |-> !rx_ready_pin_n)
        else $error("multifunction pin low without receive ready");
    rx_fall_a: assert property ($fell(rx_ready_pin_n) |-> $past(rx_cause) || $past(rx_cause, 2))
        else $error("receive ready fell without cause");
    tx_rise_a: assert property ($rose(tx_ready_pin_n) |-> $past(apb_wr, 2))
        else $error("transmit ready rose without write");
endmodule : urbt_sva
bind urbt_top urbt_sva #(.DEPTH(DEPTH)) i_urbt_sva (.pclk, .presetn, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .rx_valid, .rx_timeout, .tx_out, .sample_tick16,
    .tx_ready_pin_n, .rx_ready_pin_n, .multifunction_pin_n);

// ### urbt_far_model.sv
`timescale 1ns/1ps
// ----
// remote serial device
// ----
module urbt_far_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_out,
    input wire logic sample_tick16,
    input wire logic [3:0] frame_bits,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_timeout,
    output logic [11:0] frame,
    output int frames
);
    logic busy;
    logic [3:0] cnt;
    logic [3:0] idx;
    initial begin
        rx_valid = 1'b0;
        rx_timeout = 1'b0;
        rx_byte = 8'hFF;
    end
    // sampled near mid-bit, counting the shared tick
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            idx <= 4'h0;
            frames <= 0;
            frame <= 12'h000;
        end else if (sample_tick16) begin
            if (!busy && !tx_out) begin
                busy <= 1'b1;
                cnt <= 4'h1;
                idx <= 4'h0;
                frame <= 12'h000;
            end else if (busy) begin
                cnt <= cnt + 4'h1;
                if (cnt == 4'h7) begin
                    frame[idx] <= tx_out;
                    idx <= idx + 4'h1;
                    if (idx + 4'h1 == frame_bits) begin
                        busy <= 1'b0;
                        frames <= frames + 1;
                    end
                end
            end
        end
    end
    // released byte lines show the inverse, never a stale copy
    task automatic push(input logic [7:0] b, input logic tmo);
        @(posedge pclk);
        rx_valid <= !tmo;
        rx_timeout <= tmo;
        rx_byte <= b;
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_timeout <= 1'b0;
        rx_byte <= ~b;
    endtask : push
endmodule : urbt_far_model

// ### test_uart_ready_pins_baud_gen_tx.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_fail++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module test_uart_ready_pins_baud_gen_tx;
    import urbt_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_out, tick;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic rx_valid, rx_timeout, tx_rdy, rx_rdy, mf, irq, e;
    logic [7:0] rx_byte;
    logic [3:0] frame_bits;
    logic [11:0] frame;
    int frames, n_fail, n_checks, p;
    urbt_top #(.DEPTH(4)) i_urbt_top (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_byte, .rx_timeout,
        .tx_out, .sample_tick16(tick), .tx_ready_pin_n(tx_rdy), .rx_ready_pin_n(rx_rdy),
        .multifunction_pin_n(mf), .irq_out_first_channel(irq));
    urbt_far_model i_urbt_far_model (.pclk, .presetn, .tx_out, .sample_tick16(tick),
        .frame_bits, .rx_valid, .rx_byte, .rx_timeout, .frame, .frames);
    // ----
    // bus and wait helpers
    // ----
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_fail++;
            results();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic settle;
        repeat (2) @(posedge pclk);
    endtask : settle
    task automatic per;
        int k;
        repeat (2) begin
            k = 0;
            do begin
                @(posedge pclk);
                k++;
            end while (tick !== 1'b1 && k < 20000);
            if (k >= 20000) begin
                n_fail++;
                results();
            end
        end
        p = k;
    endtask : per
    // ----
    // scenarios
    // ----
    task automatic t_reset;
        `CHK("tx_ready", 1'b0, tx_rdy)
        `CHK("rx_ready", 1'b1, rx_rdy)
        apb(0, A_FEATURE, 0);
        `CHK("feature_control_register", 8'h00, q[7:0])
        apb(0, 8'hFC, 0);
        `CHK("unmapped err", 1'b1, e)
        i_urbt_far_model.push(8'h3C, 1'b0);
        settle();
        `CHK("rx_ready byte", 1'b0, rx_rdy)
        apb(0, A_DATA, 0);
        `CHK("rx data", 8'h3C, q[7:0])
        settle();
        `CHK("rx_ready empty", 1'b1, rx_rdy)
        apb(1, A_DLL, 0);
        apb(1, A_DATA, 8'h11);
        p = 0;
        repeat (40) @(posedge pclk) p += int'(tick === 1'b1);
        `CHK("ticks at zero", 0, p)
        `CHK("tx_ready full", 1'b1, tx_rdy)
        apb(0, A_LINE_STAT, 0);
        `CHK("lsr holding", 1'b0, q[LS_HOLD_EMPTY])
    endtask : t_reset
    task automatic t_pins;
        apb(1, A_FIFO_CTRL, 8'h01);
        apb(1, A_TRG, 32'h0202);
        settle();
        `CHK("tx_ready empty", 1'b0, tx_rdy)
        apb(1, A_DATA, 8'h01);
        settle();
        `CHK("tx_ready one", 1'b1, tx_rdy)
        `CHK("irq below", 1'b1, irq)
        apb(1, A_DATA, 8'h02);
        settle();
        `CHK("irq above", 1'b0, irq)
        apb(1, A_FIFO_CTRL, FC_KEEP);
        settle();
        `CHK("tx_ready room", 1'b0, tx_rdy)
        for (int i = 3; i < 6; i++) apb(1, A_DATA, i);
        settle();
        `CHK("tx_ready full", 1'b1, tx_rdy)
        apb(0, A_FLVL, 0);
        `CHK("tx level", 8'h04, q[7:0])
        i_urbt_far_model.push(8'hA1, 1'b0);
        settle();
        `CHK("rx below trig", 1'b1, rx_rdy)
        `CHK("irq rx below", 1'b0, irq)
        i_urbt_far_model.push(8'hA2, 1'b0);
        settle();
        `CHK("rx at trig", 1'b0, rx_rdy)
        `CHK("irq rx above", 1'b1, irq)
        apb(0, A_DATA, 0);
        settle();
        `CHK("rx sticky", 1'b0, rx_rdy)
        apb(0, A_DATA, 0);
        settle();
        `CHK("rx emptied", 1'b1, rx_rdy)
        i_urbt_far_model.push(8'hA3, 1'b0);
        i_urbt_far_model.push(8'h00, 1'b1);
        apb(1, A_ALT_FUNC, 8'h04);
        settle();
        `CHK("rx timeout", 1'b0, rx_rdy)
        `CHK("mf routed", 1'b0, mf)
        apb(0, A_DATA, 0);
        apb(1, A_FEATURE, 8'h08);
        settle();
        `CHK("mf empty", 1'b1, mf)
        `CHK("irq hdx above", 1'b0, irq)
        apb(1, A_DLL, 8'h01);
        repeat (800) @(posedge pclk);
        apb(0, A_LINE_STAT, 0);
        `CHK("lsr idle", 2'b11, q[6:5])
        `CHK("irq hdx empty", 1'b1, irq)
        `CHK("last frame", 12'h208, frame)
        apb(1, A_FEATURE, 8'h00);
    endtask : t_pins
    task automatic t_frame;
        logic [7:0] lc[3] = '{8'h03, 8'h1A, 8'h04};
        logic [7:0] by[3] = '{8'hA5, 8'h57, 8'h13};
        logic [3:0] fb[3] = '{4'hA, 4'hA, 4'h8};
        logic [11:0] ex[3] = '{12'h34A, 12'h3AE, 12'h0E6};
        int n, k;
        for (int i = 0; i < 3; i++) begin
            apb(1, A_LCR, lc[i]);
            frame_bits <= fb[i];
            n = frames;
            apb(1, A_DATA, by[i]);
            apb(0, A_LINE_STAT, 0);
            `CHK("lsr busy", 2'b01, q[6:5])
            k = 0;
            while (frames == n && k < 400) begin
                @(posedge pclk);
                k++;
            end
            if (k >= 400) begin
                n_fail++;
                results();
            end
            `CHK("frame", ex[i], frame)
            // let the stop bits finish before the next frame is set up
            repeat (40) @(posedge pclk);
        end
        apb(1, A_LCR, 8'h03);
    endtask : t_frame
    task automatic t_baud;
        apb(1, A_DIV_HI, 8'h09);
        apb(1, A_DLL, 8'h00);
        apb(0, A_DIV_HI, 0);
        `CHK("div high", 8'h09, q[7:0])
        per();
        `CHK("period 2304", 2304, p)
        apb(1, A_MODEM_CTRL, 8'h80);
        per();
        `CHK("period x4", 9216, p)
        apb(1, A_MODEM_CTRL, 8'h00);
        apb(1, A_DIV_HI, 8'h00);
        apb(1, A_DLL, 8'h03);
        per();
        `CHK("period 3", 3, p)
    endtask : t_baud
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        frame_bits = 4'hA;
        n_fail = 0;
        n_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_pins();
        t_frame();
        t_baud();
        results();
    end
endmodule : test_uart_ready_pins_baud_gen_tx
